// ==== core/ccs_pkg.sv ====
// charge cycle sequencer package: encodings and timing constants
// assumes a 40 MHz clock; used by the sequencer, not by its bench
package ccs_pkg;

  // ****************************************************************
  // clock and deglitch timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned DPM_DEGLITCH_US = 1000;   // input regulation
  localparam int unsigned THERMAL_REGULATION_DEGLITCH_US = 10000; // thermal regulation
  localparam int unsigned OK_PULSE_US     = 256;    // least low time
  localparam int unsigned DPM_DEGLITCH_CYC  = DPM_DEGLITCH_US * 40;
  localparam int unsigned THERMAL_REGULATION_DEGLITCH_CYC = THERMAL_REGULATION_DEGLITCH_US * 40;
  localparam int unsigned OK_PULSE_CYC      = OK_PULSE_US * 40;

  // ****************************************************************
  // safety timer defaults, in ticks (tick period is a parameter)
  // ****************************************************************
  localparam int unsigned TICK_CYC_DEF    = 40000000; // one second
  localparam int unsigned PRE_LIMIT_DEF   = 7200;     // two hours
  localparam int unsigned FAST_LIMIT0_DEF = 18000;
  localparam int unsigned FAST_LIMIT1_DEF = 28800;
  localparam int unsigned FAST_LIMIT2_DEF = 43200;
  localparam int unsigned FAST_LIMIT3_DEF = 72000;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int unsigned CUR_W  = 16;
  localparam int unsigned TMR_W  = 24;
  localparam logic [2:0]  PHASE_RST = 3'h0;

  // ****************************************************************
  // phase status encoding
  // ****************************************************************
  localparam logic [2:0] ST_IDLE    = 3'h0;
  localparam logic [2:0] ST_TRICKLE = 3'h1;
  localparam logic [2:0] ST_PRE     = 3'h2;
  localparam logic [2:0] ST_CC      = 3'h3;
  localparam logic [2:0] ST_CV      = 3'h4;
  localparam logic [2:0] ST_DONE    = 3'h7;

  typedef enum logic [1:0] {
    CCS_IDLE,
    CCS_CHARGE,
    CCS_TERM,
    CCS_EXPIRED
  } ccs_state_type;

endpackage : ccs_pkg

// ==== core/ccs_sequencer.sv ====
// charge cycle sequencer: start, phase, clamp, termination, safety timers
// assumes synchronous inputs, one 40 MHz clock, analog loops outside
//
// How it works
// - start only when auto enabled, converter started, current nonzero, no inhibit, no faults
// - terminate in cv, above threshold, low current
// - save current on termination, restore on recharge
// - recharge when battery falls below selected threshold
// - inhibit fall or current zero-to-nonzero restarts
// - three bit phase status encoding
// - trickle clamps to short-battery current if enabled
// - precharge clamps to precharge setting if enabled
// - regulation loops suppress termination
// - 1 ms and 10 ms regulation deglitch
// - termination sets done and pulses ok low
// - expiry zeroes current, flags, status idle, pulses
// - expired flag holds until timer reset
// - timer disable removes the timer entirely
// - half rate during regulation when enabled
// - half-rate change keeps accumulated count
// - charging faults pause the timer
// - restart, precharge/fast move, duration change clear timer
// - timer disable resets, re-enable counts from zero
// - two hour precharge timer below min voltage
`timescale 1ns/1ps
`default_nettype none

module ccs_sequencer #(
  parameter int unsigned TICK_CYC   = ccs_pkg::TICK_CYC_DEF,
  parameter int unsigned PRE_LIMIT  = ccs_pkg::PRE_LIMIT_DEF,
  parameter int unsigned FAST_LIM0  = ccs_pkg::FAST_LIMIT0_DEF,
  parameter int unsigned FAST_LIM1  = ccs_pkg::FAST_LIMIT1_DEF,
  parameter int unsigned FAST_LIM2  = ccs_pkg::FAST_LIMIT2_DEF,
  parameter int unsigned FAST_LIM3  = ccs_pkg::FAST_LIMIT3_DEF,
  parameter int unsigned DPM_DEG    = ccs_pkg::DPM_DEGLITCH_CYC,
  parameter int unsigned THERMAL_REGULATION_DEG   = ccs_pkg::THERMAL_REGULATION_DEGLITCH_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // host control
  input  wire logic        auto_charge_enable,
  input  wire logic        charge_inhibit,
  input  wire logic        host_current_wr,
  input  wire logic [15:0] host_current_data,
  input  wire logic [3:0]  recharge_threshold_sel,
  input  wire logic        low_voltage_clamp_enable,
  input  wire logic [15:0] precharge_current_setting,
  input  wire logic [15:0] short_battery_current_clamp,
  input  wire logic [15:0] termination_current_setting,
  input  wire logic        charge_ok_pulse_enable,
  input  wire logic [1:0]  safety_timer_duration,
  input  wire logic        safety_timer_enable,
  input  wire logic        timer_half_rate_enable,
  // analog status
  input  wire logic        converter_started,
  input  wire logic        charge_fault,
  input  wire logic        below_short_battery,
  input  wire logic        below_min_system,
  input  wire logic        above_recharge_thr,
  input  wire logic        cv_loop_active,
  input  wire logic        current_below_term,
  input  wire logic        input_current_regulation,
  input  wire logic        input_voltage_regulation,
  input  wire logic        thermal_regulation,
  // results
  output logic [15:0]      charge_current_setting,
  output logic [15:0]      charge_current_limit,
  output logic [2:0]       charge_phase_status,
  output logic             safety_timer_expired_flag,
  output logic             charge_ok_output,
  output logic             charging_active
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    ccs_pkg::ccs_state_type st;
    logic [15:0] cur;
    logic [15:0] saved;
    logic [15:0] lim;
    logic [2:0]  phase;
    logic        expired;
    logic [23:0] tmr;
    logic [31:0] tick;
    logic        half;
    logic [23:0] dpm_cnt;
    logic [23:0] thermal_regulation_cnt;
    logic        dpm_ok;
    logic        thermal_regulation_ok;
    logic [15:0] okcnt;
    logic        inh_prev;
    logic        pre_prev;
    logic [1:0]  dur_prev;
    logic        en_prev;
  } ccs_regs_type;

  ccs_regs_type r_q, r_d;

  logic        dpm_raw;
  logic        reg_act;
  logic        cur_nz;
  logic        start_ok;
  logic [23:0] lim_sel;
  logic        restart;

  assign dpm_raw = input_current_regulation | input_voltage_regulation;
  assign cur_nz  = r_q.cur != 16'h0;
  assign reg_act = r_q.dpm_ok | r_q.thermal_regulation_ok;

  // start conditions
  assign start_ok = converter_started & auto_charge_enable & cur_nz &
                    ~charge_inhibit & ~charge_fault & ~r_q.expired;

  // active timer limit: precharge fixed, fast from duration field
  always_comb begin
    if (below_min_system)
      lim_sel = 24'(PRE_LIMIT);
    else begin
      case (safety_timer_duration)
        2'h0:    lim_sel = 24'(FAST_LIM0);
        2'h1:    lim_sel = 24'(FAST_LIM1);
        2'h2:    lim_sel = 24'(FAST_LIM2);
        default: lim_sel = 24'(FAST_LIM3);
      endcase
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    r_d = r_q;
    restart = 1'b0;
    r_d.inh_prev = charge_inhibit;
    r_d.pre_prev = below_min_system;
    r_d.dur_prev = safety_timer_duration;
    r_d.en_prev  = safety_timer_enable;

    // deglitch counters; only a settled level counts as regulation
    if (!dpm_raw) r_d.dpm_cnt = 24'h0;
    else if (r_q.dpm_cnt != 24'(DPM_DEG)) r_d.dpm_cnt = r_q.dpm_cnt + 24'h1;
    r_d.dpm_ok = dpm_raw && r_q.dpm_cnt == 24'(DPM_DEG);
    if (!thermal_regulation) r_d.thermal_regulation_cnt = 24'h0;
    else if (r_q.thermal_regulation_cnt != 24'(THERMAL_REGULATION_DEG))
      r_d.thermal_regulation_cnt = r_q.thermal_regulation_cnt + 24'h1;
    r_d.thermal_regulation_ok = thermal_regulation && r_q.thermal_regulation_cnt == 24'(THERMAL_REGULATION_DEG);

    // host writes of the charge current; zero-to-nonzero restarts
    if (host_current_wr) begin
      r_d.cur = host_current_data;
      if (!cur_nz && host_current_data != 16'h0) restart = 1'b1;
    end
    if (r_q.inh_prev && !charge_inhibit) restart = 1'b1;

    if (r_q.okcnt != 16'h0) r_d.okcnt = r_q.okcnt - 16'h1;

    case (r_q.st)
      ccs_pkg::CCS_IDLE: begin
        r_d.phase = ccs_pkg::ST_IDLE;
        if (start_ok) r_d.st = ccs_pkg::CCS_CHARGE;
      end
      ccs_pkg::CCS_CHARGE: begin
        if (!start_ok && !(host_current_wr && restart)) begin
          r_d.st = ccs_pkg::CCS_IDLE;
          r_d.phase = ccs_pkg::ST_IDLE;
        end else if (above_recharge_thr && cv_loop_active &&
                     current_below_term && !reg_act) begin
          r_d.st = ccs_pkg::CCS_TERM;
          r_d.saved = r_q.cur;
          r_d.cur = 16'h0;
          r_d.phase = ccs_pkg::ST_DONE;
          if (charge_ok_pulse_enable)
            r_d.okcnt = 16'(ccs_pkg::OK_PULSE_CYC);
        end else if (below_short_battery)
          r_d.phase = ccs_pkg::ST_TRICKLE;
        else if (below_min_system)
          r_d.phase = ccs_pkg::ST_PRE;
        else if (cv_loop_active)
          r_d.phase = ccs_pkg::ST_CV;
        else
          r_d.phase = ccs_pkg::ST_CC;
      end
      ccs_pkg::CCS_TERM: begin
        // recharge when the battery sags below the selected threshold
        if (!above_recharge_thr) begin
          r_d.cur = r_q.saved;
          restart = 1'b1;
          r_d.st = ccs_pkg::CCS_IDLE;
          r_d.phase = ccs_pkg::ST_IDLE;
        end else if (restart) begin
          // an inhibit toggle brings back the logged current, else the
          // new cycle could never meet the nonzero-current start term
          if (!host_current_wr) r_d.cur = r_q.saved;
          r_d.st = ccs_pkg::CCS_IDLE;
          r_d.phase = ccs_pkg::ST_IDLE;
        end
      end
      ccs_pkg::CCS_EXPIRED: begin
        r_d.phase = ccs_pkg::ST_IDLE;
      end
      default: r_d.st = ccs_pkg::CCS_IDLE;
    endcase

    // safety timer: reset events first, then counting
    if (!safety_timer_enable || restart ||
        r_q.pre_prev != below_min_system ||
        r_q.dur_prev != safety_timer_duration) begin
      r_d.tmr = 24'h0;
      r_d.tick = 32'h0;
      r_d.half = 1'b0;
      r_d.expired = 1'b0;
      if (r_q.st == ccs_pkg::CCS_EXPIRED) r_d.st = ccs_pkg::CCS_IDLE;
    end else if (r_q.st == ccs_pkg::CCS_CHARGE && !charge_fault) begin
      if (r_q.tick == 32'(TICK_CYC - 1)) begin
        r_d.tick = 32'h0;
        // half rate skips every other tick, count itself untouched
        if (timer_half_rate_enable && reg_act) begin
          r_d.half = ~r_q.half;
          if (r_q.half) r_d.tmr = r_q.tmr + 24'h1;
        end else
          r_d.tmr = r_q.tmr + 24'h1;
      end else
        r_d.tick = r_q.tick + 32'h1;
      if (r_q.tmr >= lim_sel) begin
        r_d.st = ccs_pkg::CCS_EXPIRED;
        r_d.cur = 16'h0;
        r_d.expired = 1'b1;
        r_d.phase = ccs_pkg::ST_IDLE;
        if (charge_ok_pulse_enable)
          r_d.okcnt = 16'(ccs_pkg::OK_PULSE_CYC);
      end
    end

    // per-phase current clamps
    r_d.lim = (r_d.st == ccs_pkg::CCS_CHARGE) ? r_d.cur : 16'h0;
    if (low_voltage_clamp_enable && r_d.phase == ccs_pkg::ST_TRICKLE &&
        short_battery_current_clamp < r_d.lim)
      r_d.lim = short_battery_current_clamp;
    if (low_voltage_clamp_enable && r_d.phase == ccs_pkg::ST_PRE &&
        precharge_current_setting < r_d.lim)
      r_d.lim = precharge_current_setting;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
      r_q.st <= ccs_pkg::CCS_IDLE;
      r_q.phase <= ccs_pkg::PHASE_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign charge_current_setting    = r_q.cur;
  assign charge_current_limit      = r_q.lim;
  assign charge_phase_status       = r_q.phase;
  assign safety_timer_expired_flag = r_q.expired;
  assign charge_ok_output          = r_q.okcnt == 16'h0;
  assign charging_active           = r_q.st == ccs_pkg::CCS_CHARGE;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_term_zero;
    @(posedge clk) disable iff (!resetn)
    (r_q.st == ccs_pkg::CCS_CHARGE && r_d.st == ccs_pkg::CCS_TERM)
      |=> (charge_current_setting == 16'h0 && charge_phase_status == 3'h7);
  endproperty
  a_term_zero: assert property (p_term_zero)
    else $error("termination did not zero current");

  property p_no_term_reg;
    @(posedge clk) disable iff (!resetn)
    (charging_active && reg_act) |=> (r_q.st != ccs_pkg::CCS_TERM);
  endproperty
  a_no_term_reg: assert property (p_no_term_reg)
    else $error("terminated during regulation");

  property p_expire;
    @(posedge clk) disable iff (!resetn)
    $rose(safety_timer_expired_flag) |-> (charge_phase_status == 3'h0 &&
      charge_current_setting == 16'h0);
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry state wrong");

  property p_hold_flag;
    @(posedge clk) disable iff (!resetn)
    (safety_timer_expired_flag && safety_timer_enable &&
     $stable(safety_timer_duration) && $stable(below_min_system) &&
     !host_current_wr && !$fell(charge_inhibit))
      |=> safety_timer_expired_flag;
  endproperty
  a_hold_flag: assert property (p_hold_flag)
    else $error("expired flag dropped");

  property p_disable;
    @(posedge clk) disable iff (!resetn)
    !safety_timer_enable |=> (r_q.tmr == 24'h0 && !safety_timer_expired_flag);
  endproperty
  a_disable: assert property (p_disable)
    else $error("timer not cleared when disabled");

  property p_fault_pause;
    @(posedge clk) disable iff (!resetn)
    (charge_fault && safety_timer_enable && !restart &&
     $stable(below_min_system) && $stable(safety_timer_duration))
      |=> (r_q.tmr == $past(r_q.tmr));
  endproperty
  a_fault_pause: assert property (p_fault_pause)
    else $error("timer advanced under fault");

  property p_status_code;
    @(posedge clk) disable iff (!resetn)
    charge_phase_status != 3'h5 && charge_phase_status != 3'h6;
  endproperty
  a_status_code: assert property (p_status_code)
    else $error("reserved phase code");

  property p_trickle_clamp;
    @(posedge clk) disable iff (!resetn)
    ($past(low_voltage_clamp_enable) && charge_phase_status == 3'h1)
      |-> charge_current_limit <= $past(short_battery_current_clamp);
  endproperty
  a_trickle_clamp: assert property (p_trickle_clamp)
    else $error("trickle clamp exceeded");

  property p_ok_pulse;
    @(posedge clk) disable iff (!resetn)
    $fell(charge_ok_output) |-> !charge_ok_output [*8];
  endproperty
  a_ok_pulse: assert property (p_ok_pulse)
    else $error("charge ok pulse too short");

endmodule : ccs_sequencer

`default_nettype wire

// ==== tb/ccs_host_model.sv ====
// host controller model: owns the enable, inhibit and current writes
// assumes the sequencer samples its inputs on the rising clock edge
`timescale 1ns/1ps
`default_nettype none

module ccs_host_model (
  // clock
  input  wire logic        clk,
  // charge control
  output logic             auto_charge_enable,
  output logic             charge_inhibit,
  output logic             host_current_wr,
  output logic [15:0]      host_current_data
);
  initial begin
    auto_charge_enable = 1'b1;
    charge_inhibit     = 1'b0;
    host_current_wr    = 1'b0;
    host_current_data  = 16'h0000;
  end

  // one-cycle write strobe; data is inverted after release so a stale
  // value can never pass for a live write
  task automatic write_current(input logic [15:0] val);
    @(negedge clk);
    host_current_wr   = 1'b1;
    host_current_data = val;
    @(negedge clk);
    host_current_wr   = 1'b0;
    host_current_data = ~val;
  endtask : write_current

  // autonomous mode and inhibit levels
  task automatic set_ctl(input logic auto_on, input logic inh);
    @(negedge clk);
    auto_charge_enable = auto_on;
    charge_inhibit     = inh;
  endtask : set_ctl

  // host ends a cycle by zero current or by inhibit
  task automatic end_charge(input logic by_inhibit);
    if (by_inhibit) begin
      set_ctl(auto_charge_enable, 1'b1);
    end else begin
      write_current(16'h0000);
    end
  endtask : end_charge
endmodule : ccs_host_model

`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench: host model, status stimulus, reference model
// assumes short tick, timer and deglitch parameters set at the instance
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ****************
  // signals
  // ****************
  logic        clk, resetn, auto_charge_enable, charge_inhibit;
  logic        host_current_wr, low_voltage_clamp_enable;
  logic        charge_ok_pulse_enable, safety_timer_enable;
  logic        timer_half_rate_enable, converter_started, charge_fault;
  logic        below_short_battery, below_min_system, above_recharge_thr;
  logic        cv_loop_active, current_below_term, thermal_regulation;
  logic        input_current_regulation, input_voltage_regulation;
  logic        safety_timer_expired_flag, charge_ok_output, charging_active;
  logic [1:0]  safety_timer_duration;
  logic [2:0]  charge_phase_status;
  logic [3:0]  recharge_threshold_sel;
  logic [15:0] host_current_data, precharge_current_setting, v;
  logic [15:0] short_battery_current_clamp, termination_current_setting;
  logic [15:0] charge_current_setting, charge_current_limit;
  logic [15:0] saved_q[$];
  int          errors, compares, cyc, n;
  int          seed = 32'h7FC0;
  localparam int CUR = 0, LIM = 1, PH = 2, FLG = 3, OK = 4, ACT = 5;

  ccs_host_model ccs_host_model_inst (.*);
  ccs_sequencer #(.TICK_CYC(4), .PRE_LIMIT(8), .FAST_LIM0(12),
    .FAST_LIM1(20), .DPM_DEG(4), .THERMAL_REGULATION_DEG(8)) ccs_sequencer_inst (.*);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard: the sequence needs about 11k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      summarize();
    end
  end

  // ****************
  // reference model and compares
  // ****************
  function automatic logic [15:0] obs(input int k);
    case (k)
      CUR: return charge_current_setting;
      LIM: return charge_current_limit;
      PH: return {13'h0, charge_phase_status};
      FLG: return {15'h0, safety_timer_expired_flag};
      OK: return {15'h0, charge_ok_output};
      default: return {15'h0, charging_active};
    endcase
  endfunction : obs

  // clamps only apply while the option is set
  function automatic logic [15:0] exp_lim(input logic [15:0] c);
    logic [15:0] l;
    l = c;
    if (low_voltage_clamp_enable && below_short_battery)
      l = (short_battery_current_clamp < c) ? short_battery_current_clamp : c;
    else if (low_voltage_clamp_enable && below_min_system)
      l = (precharge_current_setting < c) ? precharge_current_setting : c;
    return l;
  endfunction : exp_lim

  function automatic logic [15:0] exp_phase();
    if (below_short_battery) return 16'h0001;
    if (below_min_system) return 16'h0002;
    return cv_loop_active ? 16'h0004 : 16'h0003;
  endfunction : exp_phase

  function automatic logic [15:0] rnd();
    return 16'h0800 + (16'($random(seed)) & 16'h07FF);
  endfunction : rnd

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic chk_in(input int g, input int lo, input int hi);
    compares++;
    if (g < lo || g > hi) begin
      errors++;
      $display("CHECK FAILED t=%0t delay %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask : chk_in

  // bounded wait; n keeps the cycles taken
  task automatic wait_eq(input int k, input logic [15:0] e, input int lim);
    n = 0;
    while (obs(k) !== e && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(obs(k), e);
  endtask : wait_eq

  task automatic hold_ne(input int k, input logic [15:0] e, input int len);
    logic bad;
    bad = 1'b0;
    repeat (len) begin
      @(negedge clk);
      bad = bad | (obs(k) === e);
    end
    chk({15'h0, bad}, 16'h0000);
  endtask : hold_ne

  task automatic start_charge();
    v = rnd();
    saved_q.push_back(v);
    ccs_host_model_inst.write_current(v);
    wait_eq(ACT, 16'h0001, 10);
    chk(obs(CUR), v);
  endtask : start_charge

  task automatic terminate();
    @(negedge clk);
    {above_recharge_thr, cv_loop_active, current_below_term} = 3'h7;
    wait_eq(PH, 16'h0007, 5);
    {cv_loop_active, current_below_term} = 2'h0;
  endtask : terminate

  // act 1 pauses by a fault, act 2 changes the duration mid-run
  task automatic run_timer(input int act, input int lo, input int hi);
    charge_ok_pulse_enable = (act == 2);
    start_charge();
    repeat (12) @(negedge clk);
    safety_timer_enable = 1'b1;
    if (act != 0) begin
      repeat (20) @(negedge clk);
      charge_fault = (act == 1);
      safety_timer_duration = (act == 2) ? 2'h1 : 2'h0;
      if (act == 1) repeat (100) @(negedge clk);
      charge_fault = 1'b0;
    end
    wait_eq(FLG, 16'h0001, 200);
    chk_in(n, lo, hi);
    chk(obs(CUR), 16'h0000);
    chk(obs(PH), 16'h0000);
    chk(obs(OK), {15'h0, act != 2});
    hold_ne(FLG, 16'h0000, 8);
    safety_timer_enable = 1'b0;
    safety_timer_duration = 2'h0;
    wait_eq(FLG, 16'h0000, 4);
  endtask : run_timer

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // ****************
  // main sequence
  // ****************
  initial begin
    {resetn, low_voltage_clamp_enable, charge_ok_pulse_enable,
     safety_timer_enable, timer_half_rate_enable, charge_fault,
     below_short_battery, below_min_system, cv_loop_active,
     current_below_term, thermal_regulation, input_current_regulation,
     input_voltage_regulation, safety_timer_duration} = '0;
    {converter_started, above_recharge_thr} = 2'h3;
    termination_current_setting = 16'h0100;
    precharge_current_setting = 16'h0400;
    short_battery_current_clamp = 16'h0200;
    recharge_threshold_sel = 4'($random(seed));
    repeat (12) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    for (int k = 0; k < 6; k++) chk(obs(k), {15'h0, k == OK});
    // each blocker in turn: inhibit, fault, converter down, auto off
    for (int b = 0; b < 4; b++) begin
      ccs_host_model_inst.set_ctl(b != 3, b == 0);
      charge_fault = (b == 1);
      converter_started = (b != 2);
      ccs_host_model_inst.write_current(rnd());
      hold_ne(ACT, 16'h0001, 20);
      ccs_host_model_inst.set_ctl(1'b1, 1'b0);
      {charge_fault, converter_started} = 2'h1;
      wait_eq(ACT, 16'h0001, 10);
      ccs_host_model_inst.end_charge(1'b0);
      wait_eq(ACT, 16'h0000, 10);
    end
    // phase and clamp table with random clamp levels
    start_charge();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      {below_short_battery, below_min_system, low_voltage_clamp_enable} = i[2:0];
      precharge_current_setting = rnd() - 16'h0400;
      short_battery_current_clamp = rnd() - 16'h0400;
      termination_current_setting = rnd();
      recharge_threshold_sel = 4'($random(seed));
      cv_loop_active = (i == 0);
      wait_eq(PH, exp_phase(), 10);
      wait_eq(LIM, exp_lim(v), 10);
    end
    // each settled regulation loop blocks termination
    charge_ok_pulse_enable = 1'b1;
    for (int r = 0; r < 3; r++) begin
      @(negedge clk);
      {below_short_battery, below_min_system, cv_loop_active} = 3'h0;
      {input_current_regulation, input_voltage_regulation,
       thermal_regulation} = 3'h4 >> r;
      repeat (12) @(negedge clk);
      {cv_loop_active, current_below_term} = 2'h3;
      hold_ne(PH, 16'h0007, 30);
      chk(obs(PH), 16'h0004);
      {input_current_regulation, input_voltage_regulation,
       thermal_regulation, cv_loop_active, current_below_term} = 5'h0;
    end
    // regulation younger than its deglitch does not block
    @(negedge clk);
    {input_voltage_regulation, cv_loop_active, current_below_term} = 3'h7;
    wait_eq(PH, 16'h0007, 3);
    chk(obs(CUR), 16'h0000);
    wait_eq(OK, 16'h0000, 3);
    wait_eq(OK, 16'h0001, 12000);
    chk_in(n, 10240, 10250);
    {input_voltage_regulation, cv_loop_active, current_below_term} = 3'h0;
    above_recharge_thr = 1'b0;
    wait_eq(CUR, saved_q[$], 10);
    wait_eq(ACT, 16'h0001, 10);
    // restarts after termination, pulse disabled
    charge_ok_pulse_enable = 1'b0;
    for (int w = 0; w < 2; w++) begin
      terminate();
      hold_ne(OK, 16'h0000, 20);
      if (w == 0) start_charge();
      else begin
        ccs_host_model_inst.end_charge(1'b1);
        ccs_host_model_inst.set_ctl(1'b1, 1'b0);
        wait_eq(ACT, 16'h0001, 10);
      end
    end
    chk(obs(FLG), 16'h0000);
    ccs_host_model_inst.end_charge(1'b0);
    // safety timers: 4-cycle tick, 12, 8 and 20 tick limits
    run_timer(0, 46, 52);
    below_min_system = 1'b1;
    run_timer(0, 30, 36);
    {below_min_system, timer_half_rate_enable, thermal_regulation} = 3'h3;
    run_timer(0, 94, 100);
    thermal_regulation = 1'b0;
    run_timer(0, 46, 52);
    timer_half_rate_enable = 1'b0;
    run_timer(1, 25, 32);
    run_timer(2, 77, 84);
    summarize();
  end
endmodule : testbench

`default_nettype wire
